// ===== inc/pie_pkg.sv
package pie_pkg;

    // Source numbering follows low-priority rank order.
    localparam int unsigned NUM_SRC     = 16;
    localparam int unsigned NUM_MODAL   = 8;
    localparam int unsigned FIRST_MODAL = 8;
    localparam int unsigned RANK_W      = 6;
    localparam int unsigned IDX_W       = 4;
    localparam int unsigned NUM_LINES   = 4;

    // CPU request lines served by this group.
    typedef enum logic [1:0] {
        PIE_LINE_ONE,
        PIE_LINE_THREE,
        PIE_LINE_FIVE,
        PIE_LINE_SIX
    } pie_line_t;

    // Pending-register position: group in [5:4], bit in [3:0].
    localparam logic [5:0] LO_POS [NUM_SRC] = '{
        6'h10, 6'h11, 6'h12, 6'h13, 6'h28, 6'h29, 6'h2a, 6'h2b,
        6'h17, 6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1c, 6'h1d, 6'h1e};
    localparam logic [5:0] HI_POS [NUM_SRC] = '{
        6'h10, 6'h11, 6'h12, 6'h13, 6'h28, 6'h29, 6'h2a, 6'h2b,
        6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h01, 6'h02, 6'h03};

    // Overall priority, lower value served first.
    localparam logic [RANK_W-1:0] LO_RANK [NUM_SRC] = '{
        6'h1c, 6'h1d, 6'h1e, 6'h1f, 6'h20, 6'h21, 6'h22, 6'h23,
        6'h2a, 6'h2b, 6'h2c, 6'h2d, 6'h2e, 6'h2f, 6'h30, 6'h31};
    localparam logic [RANK_W-1:0] HI_RANK [NUM_SRC] = '{
        6'h1c, 6'h1d, 6'h1e, 6'h1f, 6'h20, 6'h21, 6'h22, 6'h23,
        6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h06, 6'h07, 6'h08};

    // Peripheral vector codes, identical in both modes.
    localparam logic [15:0] VEC_CODE [NUM_SRC] = '{
        16'h002b, 16'h002c, 16'h002d, 16'h002e,
        16'h0039, 16'h003a, 16'h003b, 16'h003c,
        16'h0005, 16'h0006, 16'h0007, 16'h0040,
        16'h0041, 16'h0004, 16'h0001, 16'h0011};
    localparam logic [15:0] VEC_SPURIOUS = 16'h0000;

    // Line in low-priority mode; timers never change line.
    localparam pie_line_t LO_LINE [NUM_SRC] = '{
        PIE_LINE_THREE, PIE_LINE_THREE, PIE_LINE_THREE, PIE_LINE_THREE,
        PIE_LINE_THREE, PIE_LINE_THREE, PIE_LINE_THREE, PIE_LINE_THREE,
        PIE_LINE_FIVE,  PIE_LINE_FIVE,  PIE_LINE_FIVE,  PIE_LINE_FIVE,
        PIE_LINE_FIVE,  PIE_LINE_FIVE,  PIE_LINE_SIX,   PIE_LINE_SIX};

    // Register byte offsets.
    localparam logic [7:0] OFS_PEND0  = 8'h00;
    localparam logic [7:0] OFS_PEND1  = 8'h04;
    localparam logic [7:0] OFS_PEND2  = 8'h08;
    localparam logic [7:0] OFS_ENABLE = 8'h0c;
    localparam logic [7:0] OFS_CLEAR  = 8'h10;
    localparam logic [7:0] OFS_HIPRI  = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_ACK    = 8'h1c;

    // Reset values.
    localparam logic [NUM_SRC-1:0]   RST_ENABLE = 16'h0000;
    localparam logic [NUM_MODAL-1:0] RST_HIPRI  = 8'h00;
    localparam logic [NUM_SRC-1:0]   RST_ALL    = 16'hffff;

    // APB request from the master.
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } pie_apb_req_t;

    // Vector answer to the CPU.
    typedef struct packed {
        logic        valid;
        logic [15:0] code;
    } pie_vec_t;

endpackage

// ===== verilog/pie_pick.sv
`timescale 1ns/1ps
module pie_pick
    import pie_pkg::*;
#(
    parameter int unsigned N = 16,
    parameter int unsigned W = 6
) (
    input  wire logic [N-1:0]         cand_in,  // Candidate sources.
    input  wire logic [N*W-1:0]       rank_in,  // Rank per source, flat.
    output logic                      found_out, // Any candidate present.
    output logic [$clog2(N)-1:0]      idx_out   // Winning source index.
);

    // Lowest rank wins; a strict compare keeps the lower index on a tie.
    always_comb begin
        logic [W-1:0] best;
        best      = '1;
        found_out = 1'b0;
        idx_out   = '0;
        for (int i = 0; i < N; i++) begin
            if (cand_in[i] && (!found_out || rank_in[i*W +: W] < best)) begin
                best      = rank_in[i*W +: W];
                found_out = 1'b1;
                idx_out   = ($clog2(N))'(i);
            end
        end
    end

endmodule

// ===== verilog/pie_top.sv
`timescale 1ns/1ps
module pie_top
    import pie_pkg::*;
#(
    parameter logic [NUM_SRC-1:0] SRC_PRESENT = 16'hffff
) (
    input  wire logic         core_clk_in,         // 40 MHz core clock.
    input  wire logic         rst_in,              // Synchronous reset, active high.
    // Peripheral event requests.
    input  wire logic         tmr2_period_evt_in,   // Unit A timer 2 period.
    input  wire logic         tmr2_compare_evt_in,  // Unit A timer 2 compare.
    input  wire logic         tmr2_underflow_evt_in, // Unit A timer 2 underflow.
    input  wire logic         tmr2_overflow_evt_in, // Unit A timer 2 overflow.
    input  wire logic         tmr4_period_evt_in,   // Unit B timer 4 period.
    input  wire logic         tmr4_compare_evt_in,  // Unit B timer 4 compare.
    input  wire logic         tmr4_underflow_evt_in, // Unit B timer 4 underflow.
    input  wire logic         tmr4_overflow_evt_in, // Unit B timer 4 overflow.
    input  wire logic         sync_serial_req_in,   // Synchronous serial port.
    input  wire logic         async_rx_req_in,      // Asynchronous receiver.
    input  wire logic         async_tx_req_in,      // Asynchronous transmitter.
    input  wire logic         net_mailbox_req_in,   // Network mailbox.
    input  wire logic         net_error_req_in,     // Network error.
    input  wire logic         conv_done_req_in,     // Converter completion.
    input  wire logic         ext_pin_req_a_in,     // External pin A.
    input  wire logic         ext_pin_req_b_in,     // External pin B.
    // CPU side.
    output logic              cpu_line_one_out,     // Line one request.
    output logic              cpu_line_three_out,   // Line three request.
    output logic              cpu_line_five_out,    // Line five request.
    output logic              cpu_line_six_out,     // Line six request.
    input  wire logic         vec_fetch_in,         // One-cycle vector fetch strobe.
    input  wire pie_line_t    vec_line_in,          // Line being acknowledged.
    output pie_vec_t          periph_vector_code_out, // Registered vector answer.
    output logic              irq_out,              // Any enabled pending source.
    // APB slave.
    input  wire pie_apb_req_t apb_in,               // Setup/access request.
    output logic              pready_out,           // Always ready.
    output logic [31:0]       prdata_out,           // Registered read data.
    output logic              pslverr_out           // Unmapped address.
);

    logic [NUM_SRC-1:0]   src_req;
    logic [NUM_SRC-1:0]   pend_q;
    logic [NUM_SRC-1:0]   pend_d;
    logic [NUM_SRC-1:0]   en_q;
    logic [NUM_SRC-1:0]   ack_q;
    logic [NUM_MODAL-1:0] hipri_q;
    logic [NUM_SRC-1:0]   sw_clr;
    logic [NUM_SRC-1:0]   fetch_clr;
    logic [NUM_SRC-1:0]   cand [NUM_LINES];
    logic [NUM_LINES-1:0] line_found;
    logic [IDX_W-1:0]     line_idx [NUM_LINES];
    logic [NUM_SRC*RANK_W-1:0] rank_flat;
    logic                 wr_en;
    logic                 setup_rd;
    logic                 addr_ok;
    logic [31:0]          rdata_q;
    logic [31:0]          rdata_d;
    pie_vec_t             vec_q;
    logic [IDX_W-1:0]     sel_idx;
    logic                 sel_found;

    // Whether a source currently runs in high-priority mode.
    function automatic logic is_hi(input int unsigned i, input logic [NUM_MODAL-1:0] hp);
        if (i >= FIRST_MODAL) begin
            return hp[i - FIRST_MODAL];
        end
        return 1'b0;
    endfunction

    // Line that a source raises in its current mode.
    function automatic pie_line_t line_of(input int unsigned i,
                                          input logic [NUM_MODAL-1:0] hp);
        if (is_hi(i, hp)) begin
            return PIE_LINE_ONE;
        end
        return LO_LINE[i];
    endfunction

    // Pending-register position of a source in its current mode.
    function automatic logic [5:0] pos_of(input int unsigned i,
                                          input logic [NUM_MODAL-1:0] hp);
        if (is_hi(i, hp)) begin
            return HI_POS[i];
        end
        return LO_POS[i];
    endfunction

    // Pending bits gathered into one of the three group views.
    function automatic logic [31:0] group_view(input logic [1:0] grp,
                                               input logic [NUM_SRC-1:0] pend,
                                               input logic [NUM_MODAL-1:0] hp);
        logic [31:0] v;
        logic [5:0]  p;
        v = 32'h0000_0000;
        for (int i = 0; i < NUM_SRC; i++) begin
            p = pos_of(i, hp);
            if (p[5:4] == grp) begin
                v[p[3:0]] = pend[i];
            end
        end
        return v;
    endfunction

    // Requests in source order; absent peripherals are tied off here.
    assign src_req = {ext_pin_req_b_in, ext_pin_req_a_in, conv_done_req_in,
                      net_error_req_in, net_mailbox_req_in, async_tx_req_in,
                      async_rx_req_in, sync_serial_req_in,
                      tmr4_overflow_evt_in, tmr4_underflow_evt_in,
                      tmr4_compare_evt_in, tmr4_period_evt_in,
                      tmr2_overflow_evt_in, tmr2_underflow_evt_in,
                      tmr2_compare_evt_in, tmr2_period_evt_in} & SRC_PRESENT;

    // Ranks follow the mode of each modal source.
    always_comb begin
        for (int i = 0; i < NUM_SRC; i++) begin
            rank_flat[i*RANK_W +: RANK_W] = is_hi(i, hipri_q) ? HI_RANK[i] : LO_RANK[i];
        end
    end

    // Candidates per line: pending, enabled and mapped to that line.
    always_comb begin
        for (int l = 0; l < NUM_LINES; l++) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                cand[l][i] = pend_q[i] && en_q[i]
                             && (line_of(i, hipri_q) == pie_line_t'(l));
            end
        end
    end

    // One priority picker per CPU line.
    generate
        for (genvar l = 0; l < NUM_LINES; l++) begin : g_line
            pie_pick #(
                .N (NUM_SRC),
                .W (RANK_W)
            ) u_pick (
                .cand_in   (cand[l]),
                .rank_in   (rank_flat),
                .found_out (line_found[l]),
                .idx_out   (line_idx[l])
            );
        end
    endgenerate

    // Line levels follow the pickers so a masked source never shows.
    assign cpu_line_one_out   = line_found[PIE_LINE_ONE];
    assign cpu_line_three_out = line_found[PIE_LINE_THREE];
    assign cpu_line_five_out  = line_found[PIE_LINE_FIVE];
    assign cpu_line_six_out   = line_found[PIE_LINE_SIX];
    assign irq_out            = |(pend_q & en_q);

    // Winner of the line that the CPU acknowledges.
    assign sel_found = line_found[vec_line_in];
    assign sel_idx   = line_idx[vec_line_in];

    // The fetch clears only the delivered source, so others keep waiting.
    always_comb begin
        fetch_clr = '0;
        if (vec_fetch_in && sel_found) begin
            fetch_clr[sel_idx] = 1'b1;
        end
    end

    // APB decode. The slave never waits, so pready is tied high.
    assign pready_out = 1'b1;
    assign wr_en      = apb_in.psel && apb_in.penable && apb_in.pwrite && addr_ok;
    assign setup_rd   = apb_in.psel && !apb_in.penable && !apb_in.pwrite;
    assign prdata_out = rdata_q;

    always_comb begin
        unique case (apb_in.paddr)
            OFS_PEND0, OFS_PEND1, OFS_PEND2, OFS_ENABLE,
            OFS_CLEAR, OFS_HIPRI, OFS_STATUS, OFS_ACK: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    assign pslverr_out = apb_in.psel && apb_in.penable && !addr_ok;

    // Software clear is write-one-to-clear on the status layout.
    assign sw_clr = (wr_en && apb_in.paddr == OFS_CLEAR) ? apb_in.pwdata[NUM_SRC-1:0] : '0;

    // A new request beats any clear in the same cycle so no event is lost.
    assign pend_d = ((pend_q & ~sw_clr & ~fetch_clr) | src_req) & SRC_PRESENT;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            pend_q <= '0;
        end else begin
            pend_q <= pend_d;
        end
    end

    // Enable register; absent sources cannot be enabled.
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            en_q <= RST_ENABLE;
        end else if (wr_en && apb_in.paddr == OFS_ENABLE) begin
            en_q <= apb_in.pwdata[NUM_SRC-1:0] & SRC_PRESENT;
        end
    end

    // Mode register. Changing a mode while pending moves the request to the new line.
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            hipri_q <= RST_HIPRI;
        end else if (wr_en && apb_in.paddr == OFS_HIPRI) begin
            hipri_q <= apb_in.pwdata[NUM_MODAL-1:0];
        end
    end

    // Acknowledge record: one-hot of the source delivered by the last fetch; zero after an empty fetch.
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            ack_q <= '0;
        end else if (vec_fetch_in) begin
            ack_q <= fetch_clr;
        end
    end

    // Vector answer one cycle after the fetch; zero when nothing waits.
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            vec_q <= '0;
        end else begin
            vec_q.valid <= vec_fetch_in;
            if (vec_fetch_in) begin
                vec_q.code <= sel_found ? VEC_CODE[sel_idx] : VEC_SPURIOUS;
            end
        end
    end

    assign periph_vector_code_out = vec_q;

    // Read mux; clear register reads as zero.
    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (apb_in.paddr)
            OFS_PEND0:  rdata_d = group_view(2'h0, pend_q, hipri_q);
            OFS_PEND1:  rdata_d = group_view(2'h1, pend_q, hipri_q);
            OFS_PEND2:  rdata_d = group_view(2'h2, pend_q, hipri_q);
            OFS_ENABLE: rdata_d[NUM_SRC-1:0] = en_q;
            OFS_HIPRI:  rdata_d[NUM_MODAL-1:0] = hipri_q;
            OFS_STATUS: rdata_d[NUM_SRC-1:0] = pend_q;
            OFS_ACK:    rdata_d[NUM_SRC-1:0] = ack_q;
            default:    rdata_d = 32'h0000_0000;
        endcase
    end

    // Read data is captured in the setup cycle and held through the access.
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            rdata_q <= '0;
        end else if (setup_rd) begin
            rdata_q <= rdata_d;
        end
    end

endmodule

// ===== bench/pie_top_asserts.sv
`timescale 1ns/1ps
module pie_top_asserts
    import pie_pkg::*;
(
    input wire logic         core_clk_in, rst_in,                      // Clock, reset.
    input wire logic         tmr2_period_evt_in, tmr2_compare_evt_in,  // Unit A timer.
    input wire logic         tmr2_underflow_evt_in, tmr2_overflow_evt_in, // Unit A timer.
    input wire logic         tmr4_period_evt_in, tmr4_compare_evt_in,  // Unit B timer.
    input wire logic         tmr4_underflow_evt_in, tmr4_overflow_evt_in, // Unit B timer.
    input wire logic         sync_serial_req_in, async_rx_req_in,      // Serial.
    input wire logic         async_tx_req_in, net_mailbox_req_in,      // Serial, network.
    input wire logic         net_error_req_in, conv_done_req_in,       // Network, converter.
    input wire logic         ext_pin_req_a_in, ext_pin_req_b_in,       // Pins.
    input wire logic         cpu_line_one_out, cpu_line_three_out,     // CPU lines.
    input wire logic         cpu_line_five_out, cpu_line_six_out,      // CPU lines.
    input wire logic         vec_fetch_in, irq_out, pslverr_out,       // Fetch, summary.
    input wire pie_vec_t     periph_vector_code_out,                   // Vector answer.
    input wire pie_apb_req_t apb_in                                    // Register bus.
);
    logic [15:0] req;
    logic [15:0] en_q;
    logic [15:0] en_nx;
    logic [7:0]  hp_q;
    logic [7:0]  hp_nx;
    logic        wr;

    // Shadow the enable and mode registers so line checks know what is armed.
    assign req = {ext_pin_req_b_in, ext_pin_req_a_in, conv_done_req_in, net_error_req_in,
                  net_mailbox_req_in, async_tx_req_in, async_rx_req_in, sync_serial_req_in,
                  tmr4_overflow_evt_in, tmr4_underflow_evt_in, tmr4_compare_evt_in,
                  tmr4_period_evt_in, tmr2_overflow_evt_in, tmr2_underflow_evt_in,
                  tmr2_compare_evt_in, tmr2_period_evt_in};
    assign wr    = apb_in.psel && apb_in.penable && apb_in.pwrite;
    assign en_nx = (wr && apb_in.paddr == OFS_ENABLE) ? apb_in.pwdata[15:0] : en_q;
    assign hp_nx = (wr && apb_in.paddr == OFS_HIPRI) ? apb_in.pwdata[7:0] : hp_q;

    // Shadow registers follow the bus writes.
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            en_q <= '0;
            hp_q <= '0;
        end else begin
            en_q <= en_nx;
            hp_q <= hp_nx;
        end
    end

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_answer;
        ##1 periph_vector_code_out.valid;
    endsequence
    sequence s_empty;
        ##1 (periph_vector_code_out.valid && periph_vector_code_out.code == 16'h0000);
    endsequence

    AST_FETCH_ANSWER: assert property (vec_fetch_in |-> s_answer)
        else $error("fetch got no answer");
    AST_ANSWER_CAUSE: assert property (periph_vector_code_out.valid |-> $past(vec_fetch_in))
        else $error("answer without fetch");
    AST_SPURIOUS: assert property (vec_fetch_in && !irq_out && (&en_q) && !(|req) |-> s_empty)
        else $error("empty fetch gave nonzero code");
    AST_MASKED: assert property (en_q == 16'h0000 |-> !irq_out)
        else $error("request with all sources masked");
    AST_SUMMARY: assert property (irq_out == (cpu_line_one_out || cpu_line_three_out ||
                                             cpu_line_five_out || cpu_line_six_out))
        else $error("summary disagrees with lines");
    AST_LINE_THREE: assert property ((|(req[7:0] & en_nx[7:0])) && !vec_fetch_in
                                     |=> cpu_line_three_out)
        else $error("timer event missed line three");
    AST_LINE_FIVE: assert property ((|(req[13:8] & en_nx[13:8] & ~hp_nx[5:0])) && !vec_fetch_in
                                    |=> cpu_line_five_out)
        else $error("low mode request missed line five");
    AST_LINE_SIX: assert property ((|(req[15:14] & en_nx[15:14] & ~hp_nx[7:6])) && !vec_fetch_in
                                   |=> cpu_line_six_out)
        else $error("pin request missed line six");
    AST_LINE_ONE: assert property ((|(req[15:8] & en_nx[15:8] & hp_nx)) && !vec_fetch_in
                                   |=> cpu_line_one_out)
        else $error("high mode request missed line one");
    AST_SLVERR: assert property (apb_in.psel && apb_in.penable &&
                                 (apb_in.paddr > OFS_ACK || apb_in.paddr[1:0] != 2'h0)
                                 |-> pslverr_out)
        else $error("unmapped access not flagged");
endmodule

bind pie_top pie_top_asserts pie_top_asserts_i (.*);

// ===== bench/pie_cpu_model.sv
`timescale 1ns/1ps
module pie_cpu_model
    import pie_pkg::*;
(
    input  wire logic       clk_in,   // Core clock.
    input  wire logic       rst_in,   // Synchronous reset.
    input  wire logic       go_in,    // Start one vector fetch.
    input  wire pie_line_t  line_in,  // Line to acknowledge.
    input  wire logic [3:0] gap_in,   // Cycles to dawdle first.
    input  wire pie_vec_t   vec_in,   // Vector answer.
    output logic            fetch_out, // Fetch strobe.
    output pie_line_t       line_out, // Line with the strobe.
    output logic [15:0]     code_out, // Last code taken.
    output logic            done_out  // Code taken this cycle.
);
    logic [1:0] st_q;
    logic [3:0] cnt_q;
    pie_line_t  ln_q;

    // One fetch at a time, so a line is never served again before its code is in hand.
    always_ff @(posedge clk_in) begin
        fetch_out <= 1'b0;
        done_out  <= 1'b0;
        line_out  <= pie_line_t'(~ln_q);  // Line select is junk outside the strobe.
        if (rst_in) begin
            st_q <= 2'h0;
            ln_q <= PIE_LINE_ONE;
        end else begin
            case (st_q)
                2'h0: begin
                    if (go_in) begin
                        cnt_q <= gap_in;
                        ln_q  <= line_in;
                        st_q  <= 2'h1;
                    end
                end
                2'h1: begin
                    if (cnt_q == 4'h0) begin
                        fetch_out <= 1'b1;
                        line_out  <= ln_q;
                        st_q      <= 2'h2;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                2'h2: st_q <= 2'h3;
                default: begin
                    if (vec_in.valid) begin
                        code_out <= vec_in.code;
                        done_out <= 1'b1;
                        st_q     <= 2'h0;
                    end
                end
            endcase
        end
    end
endmodule

// ===== bench/pie_top_tb_top.sv
`timescale 1ns/1ps
module pie_top_tb_top;
    import pie_pkg::*;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic [15:0]  req = '0;
    pie_apb_req_t apb = '0;
    logic         go = 1'b0;
    pie_line_t    go_line = PIE_LINE_ONE;
    logic [3:0]   gap = 4'h0;
    logic         fetch, pready, pslverr, irq, done, serr;
    pie_line_t    fline;
    pie_vec_t     vec;
    logic [15:0]  code;
    logic [31:0]  prdata, rd;
    logic [3:0]   lines;
    logic [15:0]  exp_code [16] = '{16'h002b, 16'h002c, 16'h002d, 16'h002e, 16'h0039,
        16'h003a, 16'h003b, 16'h003c, 16'h0005, 16'h0006, 16'h0007, 16'h0040, 16'h0041,
        16'h0004, 16'h0001, 16'h0011};
    int           err_total = 0;
    int           checks = 0;

    // Free-running core clock.
    always #12.5 clk = ~clk;

    pie_top pie_top_i (
        .core_clk_in (clk), .rst_in (rst),
        .tmr2_period_evt_in (req[0]), .tmr2_compare_evt_in (req[1]),
        .tmr2_underflow_evt_in (req[2]), .tmr2_overflow_evt_in (req[3]),
        .tmr4_period_evt_in (req[4]), .tmr4_compare_evt_in (req[5]),
        .tmr4_underflow_evt_in (req[6]), .tmr4_overflow_evt_in (req[7]),
        .sync_serial_req_in (req[8]), .async_rx_req_in (req[9]), .async_tx_req_in (req[10]),
        .net_mailbox_req_in (req[11]), .net_error_req_in (req[12]), .conv_done_req_in (req[13]),
        .ext_pin_req_a_in (req[14]), .ext_pin_req_b_in (req[15]),
        .cpu_line_one_out (lines[0]), .cpu_line_three_out (lines[1]),
        .cpu_line_five_out (lines[2]), .cpu_line_six_out (lines[3]),
        .vec_fetch_in (fetch), .vec_line_in (fline), .periph_vector_code_out (vec),
        .irq_out (irq), .apb_in (apb), .pready_out (pready), .prdata_out (prdata),
        .pslverr_out (pslverr)
    );

    pie_cpu_model pie_cpu_model_i (
        .clk_in (clk), .rst_in (rst), .go_in (go), .line_in (go_line), .gap_in (gap),
        .vec_in (vec), .fetch_out (fetch), .line_out (fline), .code_out (code),
        .done_out (done)
    );

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bus cycle: setup, then access held until ready is seen at an edge.
    task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge clk);
        apb.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            err_total++;
            tally_and_finish();
        end
        rd = prdata;
        serr = pslverr;
        apb <= '0;
    endtask

    task automatic pulse(input logic [15:0] m);
        @(posedge clk);
        req <= m;
        @(posedge clk);
        req <= '0;
    endtask

    // Lines are packed as six, five, three, one.
    task automatic chk_lines(input logic [3:0] exp);
        @(posedge clk);
        cmp32({28'h0, lines}, {28'h0, exp});
    endtask

    task automatic fetch_chk(input pie_line_t l, input logic [3:0] g, input logic [15:0] exp);
        int n;
        n = 0;
        @(posedge clk);
        go <= 1'b1;
        go_line <= l;
        gap <= g;
        @(posedge clk);
        go <= 1'b0;
        while (done !== 1'b1 && n < 32) begin
            @(posedge clk);
            n++;
        end
        if (done !== 1'b1) begin
            err_total++;
            tally_and_finish();
        end
        cmp32({16'h0, code}, {16'h0, exp});
    endtask

    // Guard against a hang anywhere in the sequence.
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        apb_xfer(1'b0, 8'h0c, 32'h0);
        cmp32(rd, 32'h0);
        apb_xfer(1'b0, 8'h14, 32'h0);
        cmp32(rd, 32'h0);
        apb_xfer(1'b0, 8'h20, 32'h0);
        cmp1(serr, 1'b1);
        $display("reset test done");
        pulse(16'h0001);
        chk_lines(4'h0);
        cmp1(irq, 1'b0);
        apb_xfer(1'b0, 8'h18, 32'h0);
        cmp32(rd, 32'h1);
        apb_xfer(1'b1, 8'h0c, 32'hffff);
        chk_lines(4'h2);
        apb_xfer(1'b1, 8'h10, 32'h1);
        chk_lines(4'h0);
        $display("mask test done");
        pulse(16'hffff);
        apb_xfer(1'b0, 8'h04, 32'h0);
        cmp32(rd, 32'h7f8f);
        apb_xfer(1'b0, 8'h08, 32'h0);
        cmp32(rd, 32'h0f00);
        chk_lines(4'he);
        for (int i = 0; i < 16; i++)
            fetch_chk((i < 8) ? PIE_LINE_THREE : (i < 14) ? PIE_LINE_FIVE : PIE_LINE_SIX,
                      4'(i % 4), exp_code[i]);
        apb_xfer(1'b0, 8'h1c, 32'h0);
        cmp32(rd, 32'h8000);
        chk_lines(4'h0);
        fetch_chk(PIE_LINE_FIVE, 4'h2, 16'h0000);
        $display("priority test done");
        apb_xfer(1'b1, 8'h14, 32'h1);
        pulse(16'h0100);
        chk_lines(4'h1);
        apb_xfer(1'b0, 8'h00, 32'h0);
        cmp32(rd, 32'h10);
        fetch_chk(PIE_LINE_ONE, 4'h0, 16'h0005);
        apb_xfer(1'b1, 8'h14, 32'hff);
        pulse(16'hff00);
        apb_xfer(1'b0, 8'h00, 32'h0);
        cmp32(rd, 32'h1fe);
        chk_lines(4'h1);
        fetch_chk(PIE_LINE_ONE, 4'h1, 16'h0004);
        $display("high mode test done");
        tally_and_finish();
    end
endmodule
